// ===== design/pwp_target.sv
`timescale 1ns/10ps
module pwp_target
  import pwp_pkg::*;
#(
  parameter int HIT_W = PWP_HIT_W
) (
  input  wire logic                clk_sys_in,
  input  wire logic                rst_b_in,
  pwp_pci_if.tgt                   pci,
  input  wire logic                addr_match_in,
  input  wire logic                dword_aligned_in,
  input  wire logic                backend_ready_n_in,
  output logic [HIT_W-1:0]         window_sel_out,
  output logic [PWP_QW_W-1:0]      local_write_data_bus_out,
  output logic [PWP_BE_W*2-1:0]    local_write_be_out,
  output logic                     low_half_xfer_strobe_n_out,
  output logic                     high_half_xfer_strobe_n_out
);
  initial begin
    if (HIT_W < 1) begin
      $error("pwp_target: window select needs at least one bit");
    end
  end

  pwp_tgt_state_t st_r, st_nxt;
  logic       framen_s1_r, framen_s2_r, irdyn_s1_r, irdyn_s2_r;
  logic [PWP_DW_W-1:0] ad_s1_r, ad_s2_r;
  logic [PWP_BE_W-1:0] be_s1_r, be_s2_r;
  logic       rdy_s1_r, rdy_n_r;
  logic       trdyn_r, trdyn_oe_r, devseln_r, devseln_oe_r;
  logic       trd_d1_r, trd_d2_r;
  logic       both_prev_r, hi_next_r, last_seen_r;
  logic       lo_n_r, hi_n_r;
  logic [HIT_W-1:0] sel_r;
  logic [PWP_QW_W-1:0] data_r;
  logic [PWP_BE_W*2-1:0] be_r;

  // pins pass two flops; the target sees the whole handshake two cycles late
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      framen_s1_r <= PWP_NEG;
      framen_s2_r <= PWP_NEG;
      irdyn_s1_r  <= PWP_NEG;
      irdyn_s2_r  <= PWP_NEG;
      ad_s1_r     <= '0;
      ad_s2_r     <= '0;
      be_s1_r     <= '0;
      be_s2_r     <= '0;
      rdy_s1_r    <= PWP_NEG;
      rdy_n_r     <= PWP_NEG;
      trd_d1_r    <= PWP_NEG;
      trd_d2_r    <= PWP_NEG;
    end else begin
      framen_s1_r <= pci.framen;
      framen_s2_r <= framen_s1_r;
      irdyn_s1_r  <= pci.irdyn;
      irdyn_s2_r  <= irdyn_s1_r;
      ad_s1_r     <= pci.ad;
      ad_s2_r     <= ad_s1_r;
      be_s1_r     <= pci.cben;
      be_s2_r     <= be_s1_r;
      rdy_s1_r    <= backend_ready_n_in;
      rdy_n_r     <= rdy_s1_r;
      // own trdyn delayed to line up with the synced irdyn and ad,
      // so a phase counts here exactly when it completed on the bus
      trd_d1_r    <= trdyn_r;
      trd_d2_r    <= trd_d1_r;
    end
  end

  wire xfer_now  = pwp_both_low(irdyn_s2_r, trd_d2_r) && (st_r == PWP_DATA);
  wire rdy_now   = !rdy_n_r;
  wire last_now  = xfer_now && framen_s2_r;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      PWP_IDLE:  if (!framen_s2_r && addr_match_in) st_nxt = PWP_WAIT;
      PWP_WAIT:  if (rdy_now) st_nxt = PWP_DATA;
      PWP_DATA:  if (last_now) st_nxt = PWP_TURN;
      PWP_TURN:  st_nxt = PWP_CLEAN;
      PWP_CLEAN: st_nxt = PWP_DONE;
      PWP_DONE:  st_nxt = PWP_IDLE;
      default:   st_nxt = PWP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= PWP_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // data path: place each dword in the half it belongs to
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_r    <= '0;
      be_r      <= '0;
      hi_next_r <= 1'b0;
    end else if (st_r == PWP_WAIT && rdy_now) begin
      hi_next_r <= dword_aligned_in;
      be_r      <= '0;
    end else if (xfer_now) begin
      if (hi_next_r) begin
        data_r[PWP_QW_W-1:PWP_DW_W] <= ad_s2_r;
        be_r[PWP_BE_W*2-1:PWP_BE_W] <= ~be_s2_r;
      end else begin
        data_r[PWP_DW_W-1:0]        <= ad_s2_r;
        be_r[PWP_BE_W-1:0]          <= ~be_s2_r;
        be_r[PWP_BE_W*2-1:PWP_BE_W] <= '0;
      end
      hi_next_r <= !hi_next_r;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lo_n_r      <= PWP_NEG;
      hi_n_r      <= PWP_NEG;
      last_seen_r <= 1'b0;
    end else begin
      lo_n_r <= PWP_NEG;
      hi_n_r <= PWP_NEG;
      if (xfer_now) begin
        last_seen_r <= framen_s2_r;
        if (hi_next_r) begin
          // qword ready; in a burst that starts dword aligned, the low half of its first qword is empty
          // trdyn only let this phase through because ready stood the
          // clock before; the live ready is two cycles later and would
          // drop a qword the master already counted as written
          hi_n_r <= trd_d2_r ? PWP_NEG : PWP_ASSERT;
        end else begin
          lo_n_r <= PWP_ASSERT;
        end
      end else if (st_r == PWP_TURN && !lo_n_r && rdy_now) begin
        hi_n_r <= PWP_ASSERT;
      end
    end
  end

  // target handshake pins
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trdyn_r      <= PWP_NEG;
      trdyn_oe_r   <= 1'b0;
      devseln_r    <= PWP_NEG;
      devseln_oe_r <= 1'b0;
      sel_r        <= '0;
    end else begin
      case (st_nxt)
        PWP_WAIT: begin
          sel_r        <= {HIT_W{1'b1}};
          devseln_r    <= PWP_ASSERT;
          devseln_oe_r <= 1'b1;
          trdyn_oe_r   <= 1'b1;
        end
        PWP_DATA: trdyn_r <= rdy_now ? PWP_ASSERT : PWP_NEG;
        PWP_TURN: begin
          trdyn_r   <= PWP_NEG;
          devseln_r <= PWP_NEG;
        end
        PWP_DONE: begin
          sel_r        <= '0;
          trdyn_oe_r   <= 1'b0;
          devseln_oe_r <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  assign pci.trdyn_o                 = trdyn_r;
  assign pci.trdyn_oe                = trdyn_oe_r;
  assign pci.devseln_o               = devseln_r;
  assign pci.devseln_oe              = devseln_oe_r;
  assign window_sel_out              = sel_r;
  assign local_write_data_bus_out    = data_r;
  assign local_write_be_out          = be_r;
  assign low_half_xfer_strobe_n_out  = lo_n_r;
  assign high_half_xfer_strobe_n_out = hi_n_r;
endmodule : pwp_target

// ===== shared/pwp_pkg.sv
package pwp_pkg;
  localparam int PWP_DW_W       = 32;
  localparam int PWP_QW_W       = 64;
  localparam int PWP_BE_W       = 4;
  localparam int PWP_HIT_W      = 2;
  localparam int PWP_FIFO_DEPTH = 16;
  // cycles from bar match to devsel, and devsel to the first data phase
  localparam int PWP_DEVSEL_DLY = 1;
  localparam logic PWP_NEG      = 1'b1;
  localparam logic PWP_ASSERT   = 1'b0;

  typedef enum logic [5:0] {
    PWP_IDLE    = 6'b000001,
    PWP_WAIT    = 6'b000010,
    PWP_DATA    = 6'b000100,
    PWP_TURN    = 6'b001000,
    PWP_CLEAN   = 6'b010000,
    PWP_DONE    = 6'b100000
  } pwp_tgt_state_t;

  // true when both active-low handshakes were asserted
  function automatic logic pwp_both_low(input logic a_n, input logic b_n);
    return (!a_n) && (!b_n);
  endfunction : pwp_both_low
endpackage : pwp_pkg

// ===== shared/pwp_pci_if.sv
`timescale 1ns/10ps
interface pwp_pci_if;
  import pwp_pkg::*;
  logic [PWP_DW_W-1:0] ad_o;
  logic                ad_oe;
  logic [PWP_BE_W-1:0] cben_o;
  logic                cben_oe;
  logic                framen_o;
  logic                framen_oe;
  logic                irdyn_o;
  logic                irdyn_oe;
  logic                trdyn_o;
  logic                trdyn_oe;
  logic                devseln_o;
  logic                devseln_oe;
  // resolved wire levels, worked out by whoever joins the two ends
  logic [PWP_DW_W-1:0] ad;
  logic [PWP_BE_W-1:0] cben;
  logic                framen;
  logic                irdyn;
  logic                trdyn;
  logic                devseln;

  modport tgt (
    input  ad, cben, framen, irdyn,
    output trdyn_o, trdyn_oe, devseln_o, devseln_oe
  );
  modport mst (
    input  trdyn, devseln,
    output ad_o, ad_oe, cben_o, cben_oe, framen_o, framen_oe, irdyn_o, irdyn_oe
  );
endinterface : pwp_pci_if

// ===== design/pwp_fifo.sv
`timescale 1ns/10ps
module pwp_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_b_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("pwp_fifo: depth must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  wire              full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire              empty = (wp_r == rp_r);
  wire              push  = wr_valid_in && !full;
  wire              pop   = rd_ready_in && !empty;

  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule : pwp_fifo

// ===== design/pwp_master.sv
`timescale 1ns/10ps
// PCI-side initiator: drains a FIFO of {last, be, dword} and runs one burst.
module pwp_master
  import pwp_pkg::*;
#(
  parameter int DEPTH = PWP_FIFO_DEPTH
) (
  input  wire logic                clk_sys_in,
  input  wire logic                rst_b_in,
  pwp_pci_if.mst                   pci,
  input  wire logic                start_in,
  input  wire logic [PWP_DW_W-1:0] addr_in,
  input  wire logic                wr_valid_in,
  output logic                     wr_ready_out,
  input  wire logic [PWP_DW_W-1:0] wr_data_in,
  input  wire logic [PWP_BE_W-1:0] wr_be_in,
  input  wire logic                wr_last_in,
  output logic                     busy_out
);
  localparam int FW = PWP_DW_W + PWP_BE_W + 1;
  logic [FW-1:0] q_data;
  logic          q_valid;
  logic          q_pop;
  logic [1:0]    ph_r;
  logic          ad_oe_r, fr_oe_r, ir_oe_r, fr_r, ir_r;
  logic [PWP_DW_W-1:0] ad_r;
  logic [PWP_BE_W-1:0] be_r;

  pwp_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_q (
    .clk_sys_in  (clk_sys_in),
    .rst_b_in    (rst_b_in),
    .wr_valid_in (wr_valid_in),
    .wr_ready_out(wr_ready_out),
    .wr_data_in  ({wr_last_in, wr_be_in, wr_data_in}),
    .rd_valid_out(q_valid),
    .rd_ready_in (q_pop),
    .rd_data_out (q_data)
  );

  // trdyn is sampled combinationally as on a real PCI bus (same clock)
  wire xfer = !ir_r && !pci.trdyn && ir_oe_r;
  wire last_sent = fr_r && ir_oe_r;
  // a dword leaves the queue only in the cycle it is put on the bus,
  // so the head is never lost to the address phase or loaded twice
  wire load = (ph_r == 2'd1) && (ir_r == PWP_NEG || xfer) && !last_sent && q_valid;
  assign q_pop = load;

  assign pci.ad_o      = ad_r;
  assign pci.ad_oe     = ad_oe_r;
  assign pci.cben_o    = be_r;
  assign pci.cben_oe   = fr_oe_r;
  assign pci.framen_o  = fr_r;
  assign pci.framen_oe = fr_oe_r;
  assign pci.irdyn_o   = ir_r;
  assign pci.irdyn_oe  = ir_oe_r;
  assign busy_out      = (ph_r != 2'd0);

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ph_r    <= 2'd0;
      ad_oe_r <= 1'b0;
      fr_oe_r <= 1'b0;
      ir_oe_r <= 1'b0;
      fr_r    <= PWP_NEG;
      ir_r    <= PWP_NEG;
      ad_r    <= '0;
      be_r    <= '0;
    end else begin
      case (ph_r)
        2'd0: if (start_in && q_valid) begin
          ph_r    <= 2'd1;
          ad_r    <= addr_in;
          be_r    <= 4'h7;
          fr_r    <= PWP_ASSERT;
          fr_oe_r <= 1'b1;
          ad_oe_r <= 1'b1;
          ir_oe_r <= 1'b1;
        end
        2'd1: begin
          if (last_sent && xfer) begin
            ph_r    <= 2'd2;
            ad_oe_r <= 1'b0;
            fr_oe_r <= 1'b0;
            ir_r    <= PWP_NEG;
          end else if (load) begin
            ad_r <= q_data[PWP_DW_W-1:0];
            be_r <= q_data[FW-2:PWP_DW_W];
            ir_r <= PWP_ASSERT;
            fr_r <= q_data[FW-1] ? PWP_NEG : PWP_ASSERT;
          end else if (xfer) begin
            ir_r <= PWP_NEG;
          end
        end
        2'd2: begin
          ph_r    <= 2'd0;
          ir_oe_r <= 1'b0;
          fr_r    <= PWP_NEG;
        end
        default: ph_r <= 2'd0;
      endcase
    end
  end
endmodule : pwp_master

// ===== dv/pwp_props.sv
`timescale 1ns/10ps
module pwp_props (
  input wire logic       clk_sys_in,
  input wire logic       rst_b_in,
  input wire logic       irdyn,
  input wire logic       trdyn,
  input wire logic       framen,
  input wire logic       trdyn_o,
  input wire logic       trdyn_oe,
  input wire logic       devseln_o,
  input wire logic       devseln_oe,
  input wire logic       backend_ready_n_in,
  input wire logic [1:0] window_sel_out,
  input wire logic       low_half_xfer_strobe_n_out,
  input wire logic       high_half_xfer_strobe_n_out
);
  wire lo   = low_half_xfer_strobe_n_out;
  wire hi   = high_half_xfer_strobe_n_out;
  wire both = !irdyn && !trdyn;
  wire rdy  = !backend_ready_n_in;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // input synchronisers smear the cause over a few cycles
  sequence s_phase_ago;
    $past(both, 2) || $past(both, 3) || $past(both, 4);
  endsequence
  sequence s_ready_ago;
    $past(rdy, 3) || $past(rdy, 4) || $past(rdy, 5) || $past(rdy, 6);
  endsequence
  property p_alt; !(!lo && !hi); endproperty
  property p_lo_one; $fell(lo) |=> lo; endproperty
  property p_hi_one; $fell(hi) |=> hi; endproperty
  property p_lo_cause; $fell(lo) |-> s_phase_ago; endproperty
  property p_hi_cause; $fell(hi) |-> s_ready_ago; endproperty
  property p_trdy_cause; $fell(trdyn) |-> s_ready_ago; endproperty
  property p_sel; (!lo || !hi) |-> window_sel_out == 2'h3; endproperty
  property p_turn; $fell(trdyn_oe) |-> $past(trdyn_o) && $past(devseln_o); endproperty
  property p_idle; $fell(devseln_oe) |-> $fell(trdyn_oe) ##[0:1] window_sel_out == 2'h0;
  endproperty
  property p_mst_rel; $rose(framen) |-> ##[1:20] irdyn; endproperty
  a_alt: assert property (p_alt) else $error("both strobes low");
  a_lo_one: assert property (p_lo_one) else $error("low strobe too long");
  a_hi_one: assert property (p_hi_one) else $error("high strobe too long");
  a_lo_cause: assert property (p_lo_cause) else $error("low strobe without phase");
  a_hi_cause: assert property (p_hi_cause) else $error("high strobe without ready");
  a_trdy_cause: assert property (p_trdy_cause) else $error("trdyn without ready");
  a_sel: assert property (p_sel) else $error("strobe outside select");
  a_turn: assert property (p_turn) else $error("released while asserted");
  a_idle: assert property (p_idle) else $error("idle release wrong");
  a_mst_rel: assert property (p_mst_rel) else $error("irdyn not released");
endmodule : pwp_props

// ===== dv/pci_tgt_wr_32to64_packer_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module pci_tgt_wr_32to64_packer_tb;
  import pwp_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        start_in = 1'b0;
  logic [31:0] addr_in = 32'h00001000;
  logic        wr_valid_in = 1'b0;
  logic        wr_ready_out;
  logic [31:0] wr_data_in = 32'h0;
  logic [3:0]  wr_be_in = 4'h0;
  logic        wr_last_in = 1'b0;
  logic        busy_out;
  logic        addr_match_in = 1'b1;
  logic        dword_aligned_in = 1'b0;
  logic        backend_ready_n_in = 1'b0;
  logic [1:0]  window_sel_out;
  logic [63:0] local_write_data_bus_out;
  logic [7:0]  local_write_be_out;
  logic        low_half_xfer_strobe_n_out;
  logic        high_half_xfer_strobe_n_out;
  logic        sel_seen;
  int          failures = 0;
  int          n_tests = 0;
  int          cyc = 0;
  bit          cap_k[$];
  bit          exp_k[$];
  logic [71:0] cap[$];
  logic [71:0] exp_d[$];
  logic [71:0] exp_m[$];
  pwp_pci_if pif();
  // released address lines show the inverse so a stale value cannot pass
  assign pif.ad      = pif.ad_oe ? pif.ad_o : ~pif.ad_o;
  assign pif.cben    = pif.cben_oe ? pif.cben_o : ~pif.cben_o;
  assign pif.framen  = pif.framen_oe ? pif.framen_o : 1'b1;
  assign pif.irdyn   = pif.irdyn_oe ? pif.irdyn_o : 1'b1;
  assign pif.trdyn   = pif.trdyn_oe ? pif.trdyn_o : 1'b1;
  assign pif.devseln = pif.devseln_oe ? pif.devseln_o : 1'b1;
  pwp_master u_pwp_master (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .pci(pif),
    .start_in(start_in), .addr_in(addr_in), .wr_valid_in(wr_valid_in),
    .wr_ready_out(wr_ready_out), .wr_data_in(wr_data_in), .wr_be_in(wr_be_in),
    .wr_last_in(wr_last_in), .busy_out(busy_out));
  pwp_target u_pwp_target (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .pci(pif),
    .addr_match_in(addr_match_in), .dword_aligned_in(dword_aligned_in),
    .backend_ready_n_in(backend_ready_n_in), .window_sel_out(window_sel_out),
    .local_write_data_bus_out(local_write_data_bus_out),
    .local_write_be_out(local_write_be_out),
    .low_half_xfer_strobe_n_out(low_half_xfer_strobe_n_out),
    .high_half_xfer_strobe_n_out(high_half_xfer_strobe_n_out));
  pwp_props u_pwp_props (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .irdyn(pif.irdyn),
    .trdyn(pif.trdyn), .framen(pif.framen), .trdyn_o(pif.trdyn_o),
    .trdyn_oe(pif.trdyn_oe), .devseln_o(pif.devseln_o), .devseln_oe(pif.devseln_oe),
    .backend_ready_n_in(backend_ready_n_in), .window_sel_out(window_sel_out),
    .low_half_xfer_strobe_n_out(low_half_xfer_strobe_n_out),
    .high_half_xfer_strobe_n_out(high_half_xfer_strobe_n_out));
  always #12.5 clk_sys_in = ~clk_sys_in;
  // every strobe is logged, only high ones would commit a qword
  always @(posedge clk_sys_in) begin
    cyc++;
    if (window_sel_out === 2'h3) sel_seen = 1'b1;
    if (!low_half_xfer_strobe_n_out || !high_half_xfer_strobe_n_out) begin
      cap_k.push_back(!high_half_xfer_strobe_n_out);
      cap.push_back({local_write_be_out, local_write_data_bus_out});
    end
    if (cyc == 6000) begin
      failures++;
      print_verdict();
    end
  end
  function automatic logic [35:0] hv(input int i);
    return {~(4'(i) ^ 4'h5), 32'hC0DE0000 + 32'(i)};
  endfunction : hv
  task automatic ex(input bit k, input int li, input int hi);
    logic [71:0] d;
    logic [71:0] m;
    logic [35:0] v;
    d = '0;
    m = '0;
    if (li >= 0) begin
      v = hv(li);
      {d[67:64], d[31:0]} = v;
      {m[67:64], m[31:0]} = '1;
    end
    if (hi >= 0) begin
      v = hv(hi);
      {d[71:68], d[63:32]} = v;
      {m[71:68], m[63:32]} = '1;
    end
    exp_k.push_back(k);
    exp_d.push_back(d);
    exp_m.push_back(m);
  endtask : ex
  task automatic fill(input int n);
    for (int i = 0; i < n; i++) begin
      wr_valid_in <= 1'b1;
      wr_data_in  <= 32'hC0DE0000 + 32'(i);
      wr_be_in    <= 4'(i) ^ 4'h5;
      wr_last_in  <= (i == n - 1);
      do @(posedge clk_sys_in); while (wr_ready_out !== 1'b1);
    end
    wr_valid_in <= 1'b0;
  endtask : fill
  task automatic go(input logic dwa, input bit stall);
    int t;
    cap_k.delete();
    cap.delete();
    sel_seen = 1'b0;
    dword_aligned_in <= dwa;
    @(posedge clk_sys_in);
    start_in <= 1'b1;
    @(posedge clk_sys_in);
    start_in <= 1'b0;
    if (stall) begin
      repeat (8) @(posedge clk_sys_in);
      backend_ready_n_in <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      backend_ready_n_in <= 1'b0;
    end
    t = 0;
    do begin
      @(posedge clk_sys_in);
      t++;
    end while ((busy_out !== 1'b0 || window_sel_out !== 2'h0 || t < 10) && t < 400);
    repeat (3) @(posedge clk_sys_in);
    `CHK(cap.size(), exp_k.size())
    for (int i = 0; i < exp_k.size() && i < cap.size(); i++) begin
      `CHK(cap_k[i], exp_k[i])
      `CHK(cap[i] & exp_m[i], exp_d[i])
    end
    `CHK(sel_seen, 1'b1)
    `CHK(window_sel_out, 2'h0)
    exp_k.delete();
    exp_d.delete();
    exp_m.delete();
  endtask : go
  task automatic t_qw_odd();
    ex(0, 0, -1); ex(1, 0, 1); ex(0, 2, -1); ex(1, 2, -1);
    fill(3);
    go(1'b0, 1'b0);
  endtask : t_qw_odd
  task automatic t_dw_odd();
    ex(1, -1, 0); ex(0, 1, -1); ex(1, 1, 2);
    fill(3);
    go(1'b1, 1'b0);
  endtask : t_dw_odd
  // a full fifo must refuse, then drain under a back-end stall
  task automatic t_full_stall();
    for (int i = 0; i < 8; i++) begin
      ex(0, 2 * i, -1);
      ex(1, 2 * i, 2 * i + 1);
    end
    fill(PWP_FIFO_DEPTH);
    wr_valid_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    `CHK(wr_ready_out, 1'b0)
    wr_valid_in <= 1'b0;
    go(1'b0, 1'b1);
  endtask : t_full_stall
  task automatic print_verdict();
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    t_qw_odd();
    t_dw_odd();
    t_full_stall();
    print_verdict();
  end
endmodule : pci_tgt_wr_32to64_packer_tb
